/* core/xiobp_defs.svh */
// constants for the external i/o bus port
`ifndef XIOBP_DEFS_SVH
`define XIOBP_DEFS_SVH

`define XIOBP_ADDR_W 8
`define XIOBP_DATA_W 8
`define XIOBP_SYS_PORT_BASE 8'h80
`define XIOBP_ENABLE_PORT 8'hec
`define XIOBP_ENABLE_BIT 4
`define XIOBP_INT_PORT 8'he0
`define XIOBP_INT_EN_BIT 3
`define XIOBP_CLK_MHZ 40
`define XIOBP_WAIT_MAX_US 500
`define XIOBP_WAIT_MAX_CYC (`XIOBP_WAIT_MAX_US * `XIOBP_CLK_MHZ)
`define XIOBP_BYTE_RST 8'h00
`define XIOBP_WAIT_RST 16'h0000

`endif

/* core/xiobp_host.sv */
// host port logic of the external i/o expansion bus
// Behaviour
// - bus signals driven only while enable set
// - eight address lines select 256 ports
// - peripherals skip ports 80h to 0ffh
// - 8-bit data path only when enabled
// - input strobe low through input cycle
// - output strobe on request plus write
// - pass opcode fetch and request strobes
// - input select turns transceiver toward cpu
// - peripheral pulls input select while read
// - input select is nand of strobe, decode
// - bus wait reaches cpu only when enabled
// - wait never held two msec
// - wait ideally under 500 us, 25%
// - interrupt forwarded only when enabled
// - live interrupt level always readable
// - interrupt delivered as fixed-vector mode 1
`timescale 1ns/1ps
`default_nettype none
`include "xiobp_defs.svh"
module xiobp_host (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // processor side
    input wire logic [7:0] cpu_addr_i,
    input wire xiobp_pkg::xiobp_byte_type cpu_data_i,
    input wire logic cpu_io_request_n_i,
    input wire logic cpu_rd_n_i,
    input wire logic cpu_wr_n_i,
    input wire logic cpu_opcode_fetch_n_i,
    input wire logic external_io_enable_i,
    input wire logic bus_interrupt_enable_i,
    output logic [7:0] cpu_data_o,
    output logic cpu_data_oe_o,
    output logic cpu_wait_n_o,
    output logic cpu_int_n_o,
    output logic bus_interrupt_status_o,
    // connector
    xiobp_if.host_end bus
);
    import xiobp_pkg::*;

    // ************************************************
    // decode helpers
    // ************************************************

    // a strobe pair is active only while both of its lows meet
    function automatic logic pair_n(input logic req_n, input logic dir_n);
        return req_n | dir_n;
    endfunction

    // one name for the kind of processor cycle under way;
    // acknowledge wins because fetch plus request is never a port access
    function automatic xiobp_cycle_type classify(
        input logic req_n,
        input logic rd_n,
        input logic wr_n,
        input logic fetch_n
    );
        xiobp_cycle_type kind;
        kind = XIOBP_IDLE;
        // read before write, so a malformed cycle is classed as a read, never a write
        if (!req_n && !fetch_n)
            kind = XIOBP_ACK;
        else if (!pair_n(req_n, rd_n))
            kind = XIOBP_READ;
        else if (!pair_n(req_n, wr_n))
            kind = XIOBP_WRITE;
        return kind;
    endfunction

    // ************************************************
    // internal signals
    // ************************************************
    // cycle kind decoded once; only the read transceiver enable uses it
    xiobp_cycle_type cycle_kind;

    // the two bus strobes, kept local so they are decoded once
    logic in_strobe_n;
    logic out_strobe_n;

    // captured byte from the bus, handed to the cpu on a read
    logic [7:0] rd_data_q;

    // live acknowledge, only honoured while the bus is enabled
    logic sel_ok;

    // ************************************************
    // cycle decode
    // ************************************************
    // interrupt acknowledge is recognised here so the read path can stay shut
    always_comb
    begin
        cycle_kind = classify(cpu_io_request_n_i, cpu_rd_n_i, cpu_wr_n_i,
            cpu_opcode_fetch_n_i);
        in_strobe_n = pair_n(cpu_io_request_n_i, cpu_rd_n_i);
        out_strobe_n = pair_n(cpu_io_request_n_i, cpu_wr_n_i);
    end

    // ************************************************
    // connector enables
    // ************************************************
    // one enable gates address, data and control; reset is not on this port
    // trade-off: a single enable makes a half-enabled bus impossible
    always_comb
    begin
        bus.ctrl_oe = external_io_enable_i;
        bus.addr_oe = external_io_enable_i;
    end

    // ************************************************
    // address
    // ************************************************
    // all eight lines are passed, so 256 ports each way are reachable
    // no latch: the address only has to hold while a strobe is low
    always_comb
    begin
        bus.addr = cpu_addr_i;
    end

    // ************************************************
    // control strobes
    // ************************************************
    // combinational so the strobes track the processor cycle exactly
    // limitation: no glitch filter; strobes are as clean as their inputs
    always_comb
    begin
        bus.in_n = in_strobe_n;
        bus.out_n = out_strobe_n;
    end

    // raw request and fetch go out untouched; peripherals spot an
    // acknowledge as both low together
    always_comb
    begin
        bus.io_request_n = cpu_io_request_n_i;
        bus.opcode_fetch_n = cpu_opcode_fetch_n_i;
    end

    // ************************************************
    // write data
    // ************************************************
    // host drives the data lines only during an enabled output cycle,
    // so it never fights a peripheral answering an input
    // the data value itself is passed through unqualified; only its drive is gated by the enable
    always_comb
    begin
        bus.data_host = cpu_data_i;
        bus.data_host_oe = external_io_enable_i & ~out_strobe_n;
    end

    // ************************************************
    // read data
    // ************************************************
    // an acknowledge while the bus is disabled is ignored outright
    always_comb
    begin
        sel_ok = external_io_enable_i & ~bus.ext_input_select_n;
    end

    // registered copy of the bus data, refreshed while acknowledged;
    // the byte lands one edge after the acknowledge, so slow
    // peripherals cover that with a wait
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_data_q <= `XIOBP_BYTE_RST;
        else if (sel_ok)
            rd_data_q <= bus.data_periph;
    end

    // transceiver turns toward the cpu only on an enabled, acknowledged read;
    // never during an interrupt acknowledge, as mode 1 wants no vector byte
    always_comb
    begin
        cpu_data_o = rd_data_q;
        cpu_data_oe_o = sel_ok & (cycle_kind == XIOBP_READ);
    end

    // ************************************************
    // wait
    // ************************************************
    // a disabled bus cannot stall the cpu, even if its wait line floats low;
    // the peripheral alone keeps each wait short enough for refresh
    always_comb
    begin
        cpu_wait_n_o = ~external_io_enable_i | bus.bus_wait_n;
    end

    // ************************************************
    // interrupt
    // ************************************************
    // level forwarded, not latched: mode 1 jumps to a fixed vector, so only
    // the request line is needed and the peripheral holds it until serviced
    always_comb
    begin
        cpu_int_n_o = ~bus_interrupt_enable_i | bus.bus_interrupt_n;
    end

    // status shows the live line whether or not forwarding is enabled;
    // software reads it through the interrupt input port
    always_comb
    begin
        bus_interrupt_status_o = ~bus.bus_interrupt_n;
    end
endmodule
`default_nettype wire

/* core/xiobp_if.sv */
// connector-side signals of the external i/o bus
`timescale 1ns/1ps
`default_nettype none
interface xiobp_if;
    logic [7:0] addr;
    logic addr_oe;
    logic [7:0] data_host;
    logic data_host_oe;
    logic [7:0] data_periph;
    logic data_periph_oe;
    logic in_n;
    logic out_n;
    logic io_request_n;
    logic opcode_fetch_n;
    logic ctrl_oe;
    logic ext_input_select_n;
    logic bus_wait_n;
    logic bus_interrupt_n;
    // host port end
    modport host_end (
        output addr, addr_oe, data_host, data_host_oe, in_n, out_n,
        output io_request_n, opcode_fetch_n, ctrl_oe,
        input data_periph, data_periph_oe, ext_input_select_n, bus_wait_n, bus_interrupt_n
    );
    // peripheral end
    modport periph_end (
        input addr, addr_oe, data_host, data_host_oe, in_n, out_n,
        input io_request_n, opcode_fetch_n, ctrl_oe,
        output data_periph, data_periph_oe, ext_input_select_n, bus_wait_n, bus_interrupt_n
    );
endinterface
`default_nettype wire

/* core/xiobp_periph.sv */
// peripheral end of the external i/o bus: one input and one output port
`timescale 1ns/1ps
`default_nettype none
`include "xiobp_defs.svh"
module xiobp_periph #(
    parameter logic [7:0] PORT_ADDR = 8'h10,
    parameter int WAIT_CYC = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // user side
    input wire xiobp_pkg::xiobp_byte_type in_data_i,
    input wire logic irq_i,
    output xiobp_pkg::xiobp_byte_type out_data_o,
    output logic out_strobe_o,
    // connector
    xiobp_if.periph_end bus
);
    import xiobp_pkg::*;

    logic hit;
    logic [15:0] wait_q;
    logic out_seen_q;
    logic in_seen_q;

    // decode refuses the reserved system range
    assign hit = bus.ctrl_oe && (PORT_ADDR < `XIOBP_SYS_PORT_BASE)
        && (bus.addr == PORT_ADDR);

    // acknowledge is nand of input strobe and decode
    always_comb
    begin
        bus.ext_input_select_n = ~(~bus.in_n & hit);
        bus.data_periph = in_data_i;
        bus.data_periph_oe = ~bus.ext_input_select_n;
        bus.bus_interrupt_n = ~irq_i;
        bus.bus_wait_n = ~(~bus.in_n & hit & ~in_seen_q);
    end

    // short wait on each read, clamped at the XIOBP_WAIT_MAX_CYC limit
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_q <= `XIOBP_WAIT_RST;
            in_seen_q <= 1'b0;
        end
        else if (bus.in_n)
        begin
            wait_q <= `XIOBP_WAIT_RST;
            in_seen_q <= 1'b0;
        end
        else if (hit && !in_seen_q)
        begin
            wait_q <= wait_q + 16'h0001;
            if (wait_q >= 16'(WAIT_CYC) || wait_q >= 16'(`XIOBP_WAIT_MAX_CYC))
                in_seen_q <= 1'b1;
        end
    end

    // latch written byte once per output cycle
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_data_o <= `XIOBP_BYTE_RST;
            out_strobe_o <= 1'b0;
            out_seen_q <= 1'b0;
        end
        else
        begin
            out_strobe_o <= 1'b0;
            if (bus.out_n)
                out_seen_q <= 1'b0;
            else if (hit && bus.data_host_oe && !out_seen_q)
            begin
                out_data_o <= bus.data_host;
                out_strobe_o <= 1'b1;
                out_seen_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* core/xiobp_pkg.sv */
// types shared by both ends of the external i/o bus port
package xiobp_pkg;
    typedef logic [7:0] xiobp_byte_type;
    typedef enum logic [1:0] {XIOBP_IDLE, XIOBP_READ, XIOBP_WRITE, XIOBP_ACK} xiobp_cycle_type;
endpackage

/* dv/external_io_bus_port_tb.sv */
// self-checking bench joining host and peripheral ends
`timescale 1ns/1ps
`default_nettype none
module external_io_bus_port_tb;
    import xiobp_pkg::*;
    logic sys_clk_i, rst_i, req_n, rd_n, wr_n, fetch_n, en, ie, irq;
    logic data_oe, wait_n, int_n, stat, strobe;
    logic [7:0] addr;
    xiobp_byte_type wdata, in_data, cpu_data, out_data;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int waits = 0;
    // rows: enable, line, expected int_n, expected status
    logic [3:0] rows [4] = '{4'b0010, 4'b0111, 4'b1010, 4'b1101};
    xiobp_if xiobp_if_inst ();
    xiobp_host xiobp_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_addr_i(addr),
        .cpu_data_i(wdata), .cpu_io_request_n_i(req_n), .cpu_rd_n_i(rd_n), .cpu_wr_n_i(wr_n),
        .cpu_opcode_fetch_n_i(fetch_n), .external_io_enable_i(en), .bus_interrupt_enable_i(ie),
        .cpu_data_o(cpu_data), .cpu_data_oe_o(data_oe), .cpu_wait_n_o(wait_n),
        .cpu_int_n_o(int_n), .bus_interrupt_status_o(stat), .bus(xiobp_if_inst));
    xiobp_periph xiobp_periph_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_data_i(in_data),
        .irq_i(irq), .out_data_o(out_data), .out_strobe_o(strobe), .bus(xiobp_if_inst));
    xiobp_checker xiobp_checker_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .addr(xiobp_if_inst.addr), .addr_oe(xiobp_if_inst.addr_oe),
        .data_host_oe(xiobp_if_inst.data_host_oe), .in_n(xiobp_if_inst.in_n),
        .data_periph_oe(xiobp_if_inst.data_periph_oe),
        .out_n(xiobp_if_inst.out_n), .io_request_n(xiobp_if_inst.io_request_n),
        .ctrl_oe(xiobp_if_inst.ctrl_oe), .bus_wait_n(xiobp_if_inst.bus_wait_n),
        .ext_input_select_n(xiobp_if_inst.ext_input_select_n));
    // 40 mhz clock
    initial
    begin
        sys_clk_i = 0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // request lines; both strobes high releases the cycle
    task automatic io(input logic [7:0] a, input logic r, input logic w);
        addr = a;
        rd_n = r;
        wr_n = w;
        req_n = r & w;
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, far above the thirty or so cycles needed
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            tally_and_finish;
        end
    end
    // ********
    // stimulus
    // ********
    initial
    begin
        {rst_i, req_n, rd_n, wr_n, fetch_n, en, ie, irq} = 8'hfc;
        addr = 8'h10;
        wdata = 8'h5a;
        in_data = 8'ha5;
        repeat (6) @(negedge sys_clk_i);
        rst_i = 0;
        chk(cpu_data, 8'h00);
        chk(strobe, 8'h00);
        foreach (rows[i])
        begin
            {ie, irq} = rows[i][3:2];
            @(negedge sys_clk_i);
            chk({int_n, stat}, rows[i][1:0]);
        end
        io(8'h10, 1, 0);
        #1 chk(xiobp_if_inst.addr, 8'h10);
        @(negedge sys_clk_i);
        chk(strobe, 8'h01);
        chk(out_data, 8'h5a);
        io(8'h10, 1, 1);
        @(negedge sys_clk_i);
        chk(strobe, 8'h00);
        // refused writes: disabled bus, then a system port
        for (int k = 0; k < 2; k++)
        begin
            en = k[0];
            io(k[0] ? 8'h90 : 8'h10, 1, 0);
            @(negedge sys_clk_i);
            chk(strobe, 8'h00);
            chk(xiobp_if_inst.ctrl_oe, {7'h00, k[0]});
            io(8'h10, 1, 1);
            @(negedge sys_clk_i);
        end
        {fetch_n, req_n} = 2'b00;
        #1 chk({xiobp_if_inst.opcode_fetch_n, xiobp_if_inst.io_request_n}, 8'h00);
        chk(data_oe, 8'h00);
        {fetch_n, req_n} = 2'b11;
        @(negedge sys_clk_i);
        io(8'h10, 0, 1);
        @(negedge sys_clk_i);
        chk({data_oe, wait_n}, 8'h02);
        // peripheral waits WAIT_CYC (4) more edges after the first
        waits = 0;
        while (!wait_n && waits < 20)
        begin
            @(negedge sys_clk_i);
            waits++;
        end
        chk(waits[7:0], 8'h04);
        chk(cpu_data, 8'ha5);
        io(8'h10, 1, 1);
        @(negedge sys_clk_i);
        en = 0;
        io(8'h10, 0, 1);
        @(negedge sys_clk_i);
        chk({data_oe, wait_n}, 8'h01);
        io(8'h10, 1, 1);
        @(negedge sys_clk_i);
        // reset in mid-run clears captured bytes, then a write works again
        rst_i = 1;
        @(negedge sys_clk_i);
        chk(out_data, 8'h00);
        chk(cpu_data, 8'h00);
        rst_i = 0;
        en = 1;
        io(8'h10, 1, 0);
        @(negedge sys_clk_i);
        chk(strobe, 8'h01);
        chk(out_data, 8'h5a);
        io(8'h10, 1, 1);
        @(negedge sys_clk_i);
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* dv/xiobp_checker.sv */
// assertion checker on the external i/o bus wires
`timescale 1ns/1ps
`default_nettype none
module xiobp_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // bus wires
    input wire logic [7:0] addr,
    input wire logic addr_oe,
    input wire logic data_host_oe,
    input wire logic data_periph_oe,
    input wire logic in_n,
    input wire logic out_n,
    input wire logic io_request_n,
    input wire logic ctrl_oe,
    input wire logic ext_input_select_n,
    input wire logic bus_wait_n
);
    // ********
    // rules on the connector
    // ********
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_oe_pair: assert property (addr_oe == ctrl_oe) else $error("oe split");
    a_drive_gate: assert property (data_host_oe |-> ctrl_oe) else $error("data drive");
    a_out_data: assert property (ctrl_oe && !out_n |-> data_host_oe) else $error("no data");
    a_out_req: assert property (ctrl_oe && !out_n |-> !io_request_n) else $error("out");
    a_in_req: assert property (ctrl_oe && !in_n |-> !io_request_n && out_n)
        else $error("in");
    a_sel_in: assert property (!ext_input_select_n |-> ctrl_oe && !in_n)
        else $error("stray select");
    a_sel_user: assert property (!ext_input_select_n |-> addr < 8'h80)
        else $error("system port");
    // wait must end long before refresh suffers
    a_wait_short: assert property ($fell(bus_wait_n) |-> ##[1:8] bus_wait_n)
        else $error("long wait");
    // a wait outside an input cycle would stall refresh for nothing
    a_wait_in: assert property (!bus_wait_n |-> !in_n) else $error("stray wait");
    // both ends driving the data lines at once means contention
    a_no_fight: assert property (!(data_host_oe && data_periph_oe))
        else $error("data contention");
    cover property (ctrl_oe && !out_n);
    cover property (!ext_input_select_n);
    cover property ($rose(bus_wait_n));
endmodule
`default_nettype wire
